/* File: src/access_seq.sv */
/*
  Cycle sequencer for one data access: address phase with latch pulse,
  strobe phase stretched by wait-states, final period.
  Assumes start is only raised while idle is high.
*/
`timescale 1ns/1ps
module access_seq (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  access_seq_if.seq bus
);
  typedef enum logic [2:0] {S_IDLE, S_INT, S_ADDR, S_STROBE, S_LAST} seq_state_t;

  seq_state_t state_q, state_d;
  logic [ext_mem_pkg::WAIT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic next_ram_q, next_ram_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    next_ram_d = next_ram_q;
    unique case (state_q)
      S_IDLE:
      begin
        if (bus.start)
        begin
          wr_d = bus.wr;
          next_ram_d = bus.next_ram;
          cnt_d = bus.waits;
          state_d = bus.ext ? S_ADDR : S_INT;
        end
      end
      S_INT: state_d = S_IDLE;
      S_ADDR: state_d = S_STROBE;
      S_STROBE:
      begin
        // one strobe clock, plus one per wait-state
        if (cnt_q == '0)
          state_d = S_LAST;
        else
          cnt_d = cnt_q - 1'b1;
      end
      S_LAST: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      next_ram_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      next_ram_q <= next_ram_d;
    end
  end

  assign bus.idle = (state_q == S_IDLE);
  // internal access two clocks, external 4 + waits: two extra plus one per wait
  assign bus.done = (state_q == S_INT) || (state_q == S_LAST);
  // latch gate high in the address phase and, with next_ram, in the final period; low through the strobe
  assign bus.ale = (state_q == S_ADDR) || ((state_q == S_LAST) && next_ram_q);
  // strobes never leave high outside S_STROBE, so internal cycles keep them quiet
  assign bus.rd_n = !((state_q == S_STROBE) && !wr_q);
  assign bus.wr_n = !((state_q == S_STROBE) && wr_q);
  assign bus.drive_data = wr_q && ((state_q == S_STROBE) || (state_q == S_LAST));
  assign bus.capture = (state_q == S_LAST) && !wr_q;
endmodule

/* File: src/access_seq_if.sv */
/*
  Handshake between the port controller and its cycle sequencer.
  Assumes both ends share sys_clk_in.
*/
`timescale 1ns/1ps
interface access_seq_if;
  logic start;
  logic ext;
  logic wr;
  logic next_ram;
  logic [ext_mem_pkg::WAIT_W-1:0] waits;
  logic idle;
  logic done;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic drive_data;
  logic capture;

  modport seq (
    input start, ext, wr, next_ram, waits,
    output idle, done, ale, rd_n, wr_n, drive_data, capture
  );
  modport ctl (
    output start, ext, wr, next_ram, waits,
    input idle, done, ale, rd_n, wr_n, drive_data, capture
  );
endinterface

/* File: src/ext_mem_pkg.sv */
/*
  Constants for the off-chip memory port: register offsets, field positions,
  reset values, address boundaries and pin-width figures.
  Assumes one 40 MHz clock and an APB master with 32-bit data.
*/
package ext_mem_pkg;
  localparam int ADDR_W = 16;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 8;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // register byte addresses
  localparam logic [APB_AW-1:0] OFS_CORE_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] OFS_CTRL_FIRST = 12'h004;
  localparam logic [APB_AW-1:0] OFS_CTRL_SECOND = 12'h008;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h00c;

  // core_control_reg fields
  localparam int CORE_ENABLE_BIT = 7;
  localparam int CORE_UPPER_WAIT_LOW_BIT = 6;
  // ext_mem_ctrl_first fields
  localparam int FIRST_LIMIT_LSB = 4;
  localparam int FIRST_LIMIT_W = 3;
  localparam int FIRST_LOWER_WAIT_LSB = 2;
  localparam int FIRST_UPPER_WAIT_HIGH_BIT = 1;
  // ext_mem_ctrl_second fields
  localparam int SECOND_KEEPER_BIT = 7;
  localparam int SECOND_RELEASE_LSB = 0;
  localparam int SECOND_RELEASE_W = 3;
  // status fields
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_COMPAT_BIT = 1;
  localparam int STATUS_ENABLED_BIT = 2;

  localparam logic [7:0] CORE_RESET = 8'h00;
  localparam logic [7:0] FIRST_RESET = 8'h00;
  localparam logic [7:0] SECOND_RESET = 8'h00;

  // last internal data-space address, normal and compatibility map
  localparam logic [ADDR_W-1:0] INT_TOP_NORMAL = 16'h10ff;
  localparam logic [ADDR_W-1:0] INT_TOP_COMPAT = 16'h0fff;

  // sector limit counts in units of this many address bits
  localparam int SECTOR_SHIFT = 13;
  localparam int WAIT_W = 2;
endpackage

/* File: src/ext_mem_port.sv */
/*
  Off-chip memory port: APB register file, access decode, pin muxing
  against the general port, bus-keeper and compatibility restrictions.
  Assumes an APB master, a core that holds req_in until done_out, and an
  external transparent address latch gated by the latch pin.
*/
`timescale 1ns/1ps
module ext_mem_port #(
  parameter int ADDR_W = ext_mem_pkg::ADDR_W,
  parameter int LOW_W = ext_mem_pkg::LOW_W,
  parameter int HIGH_W = ext_mem_pkg::HIGH_W
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ext_mem_pkg::APB_AW-1:0] paddr_in,
  input wire logic [ext_mem_pkg::APB_DW-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [ext_mem_pkg::APB_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // core data access
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [LOW_W-1:0] req_wdata_in,
  input wire logic req_next_ram_in,
  output logic done_out,
  output logic ext_hit_out,
  output logic [LOW_W-1:0] rdata_out,
  // compatibility fuse level
  input wire logic compat_mode_in,
  // general port settings used while the pins are released
  input wire logic [LOW_W-1:0] port_low_data_in,
  input wire logic [LOW_W-1:0] port_low_dir_in,
  input wire logic [HIGH_W-1:0] port_high_data_in,
  input wire logic [HIGH_W-1:0] port_high_dir_in,
  input wire logic [2:0] port_ctrl_data_in,
  input wire logic [2:0] port_ctrl_dir_in,
  // pins
  input wire logic [LOW_W-1:0] muxed_low_bus_in,
  output logic [LOW_W-1:0] muxed_low_bus_out,
  output logic [LOW_W-1:0] muxed_low_bus_oe_out,
  output logic keeper_on_out,
  output logic [LOW_W-1:0] keeper_level_out,
  output logic [HIGH_W-1:0] high_address_bus_out,
  output logic [HIGH_W-1:0] high_address_bus_oe_out,
  output logic ale_out,
  output logic ale_oe_out,
  output logic rd_n_out,
  output logic rd_n_oe_out,
  output logic wr_n_out,
  output logic wr_n_oe_out
);
  localparam int W = ext_mem_pkg::WAIT_W;
  localparam int LW = ext_mem_pkg::FIRST_LIMIT_W;
  localparam int RW = ext_mem_pkg::SECOND_RELEASE_W;

  access_seq_if sq ();

  access_seq u_seq (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .bus(sq)
  );

  // registers
  logic [7:0] core_q, core_d;
  logic [7:0] first_q, first_d;
  logic [7:0] second_q, second_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic [ext_mem_pkg::APB_DW-1:0] prdata_q, prdata_d;
  // fuse and bus input synchronisers
  logic compat_s1_q, compat_q;
  logic [LOW_W-1:0] low_s1_q, low_s2_q;
  // access state
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [LOW_W-1:0] wdata_q, wdata_d;
  logic [LOW_W-1:0] rdata_q, rdata_d;
  logic ext_q, ext_d;
  logic cap_pend_q, cap_pend_d;

  // derived configuration, compat mode masks the extended fields
  logic enabled;
  logic [W-1:0] upper_wait;
  logic [W-1:0] lower_wait;
  logic [LW-1:0] sector_limit;
  logic [RW-1:0] release_cnt;
  logic keeper_en;
  logic apb_access;
  logic is_ext;
  logic [W-1:0] sel_wait;

  function automatic logic past_internal(input logic [ADDR_W-1:0] a, input logic compat);
    past_internal = compat ? (a > ext_mem_pkg::INT_TOP_COMPAT) : (a > ext_mem_pkg::INT_TOP_NORMAL);
  endfunction

  function automatic logic [7:0] byte_write(input logic [7:0] old, input logic [ext_mem_pkg::APB_DW-1:0] wd,
                                            input logic lane);
    byte_write = lane ? wd[7:0] : old;
  endfunction

  assign enabled = core_q[ext_mem_pkg::CORE_ENABLE_BIT];
  assign upper_wait = compat_q ? {1'b0, core_q[ext_mem_pkg::CORE_UPPER_WAIT_LOW_BIT]}
                               : {first_q[ext_mem_pkg::FIRST_UPPER_WAIT_HIGH_BIT],
                                  core_q[ext_mem_pkg::CORE_UPPER_WAIT_LOW_BIT]};
  assign lower_wait = first_q[ext_mem_pkg::FIRST_LOWER_WAIT_LSB +: W];
  assign sector_limit = compat_q ? '0 : first_q[ext_mem_pkg::FIRST_LIMIT_LSB +: LW];
  assign release_cnt = compat_q ? '0 : second_q[ext_mem_pkg::SECOND_RELEASE_LSB +: RW];
  assign keeper_en = !compat_q && second_q[ext_mem_pkg::SECOND_KEEPER_BIT];

  // disabled: upper addresses are simply not served, never folded inward
  assign is_ext = enabled && past_internal(req_addr_in, compat_q);
  // lower sector below limit * 8K; limit zero means one sector
  assign sel_wait = ((sector_limit != '0) &&
                     (req_addr_in[ADDR_W-1:ext_mem_pkg::SECTOR_SHIFT] < sector_limit))
                    ? lower_wait : upper_wait;

  assign sq.start = req_in && sq.idle && !cap_pend_q;
  assign sq.ext = is_ext;
  assign sq.wr = req_write_in;
  assign sq.next_ram = req_next_ram_in;
  assign sq.waits = sel_wait;

  // apb: one wait state so read data comes from a flop
  assign apb_access = psel_in && penable_in && !ack_q;

  always_comb
  begin
    core_d = core_q;
    first_d = first_q;
    second_d = second_q;
    ack_d = apb_access;
    err_d = 1'b0;
    prdata_d = prdata_q;
    if (apb_access)
    begin
      prdata_d = '0;
      unique case (paddr_in)
        ext_mem_pkg::OFS_CORE_CTRL:
        begin
          prdata_d[7:0] = core_q;
          if (pwrite_in)
            core_d = byte_write(core_q, pwdata_in, pstrb_in[0]);
        end
        ext_mem_pkg::OFS_CTRL_FIRST:
        begin
          // absent in compat mode: reads zero, writes dropped, error flagged
          err_d = compat_q;
          if (!compat_q)
          begin
            prdata_d[7:0] = first_q;
            if (pwrite_in)
              first_d = byte_write(first_q, pwdata_in, pstrb_in[0]);
          end
        end
        ext_mem_pkg::OFS_CTRL_SECOND:
        begin
          err_d = compat_q;
          if (!compat_q)
          begin
            prdata_d[7:0] = second_q;
            if (pwrite_in)
              second_d = byte_write(second_q, pwdata_in, pstrb_in[0]);
          end
        end
        ext_mem_pkg::OFS_STATUS:
        begin
          prdata_d[ext_mem_pkg::STATUS_BUSY_BIT] = !sq.idle;
          prdata_d[ext_mem_pkg::STATUS_COMPAT_BIT] = compat_q;
          prdata_d[ext_mem_pkg::STATUS_ENABLED_BIT] = enabled;
          err_d = pwrite_in;
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  always_comb
  begin
    addr_d = addr_q;
    wdata_d = wdata_q;
    ext_d = ext_q;
    rdata_d = rdata_q;
    cap_pend_d = 1'b0;
    if (sq.start)
    begin
      addr_d = req_addr_in;
      wdata_d = req_wdata_in;
      ext_d = is_ext;
      if (!is_ext)
        rdata_d = '0;
    end
    // bus sampled through two flops, so take it one clock after the last period
    if (sq.capture)
      cap_pend_d = 1'b1;
    if (cap_pend_q)
      rdata_d = low_s2_q;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      core_q <= ext_mem_pkg::CORE_RESET;
      first_q <= ext_mem_pkg::FIRST_RESET;
      second_q <= ext_mem_pkg::SECOND_RESET;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= '0;
      compat_s1_q <= 1'b0;
      compat_q <= 1'b0;
      low_s1_q <= '0;
      low_s2_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      ext_q <= 1'b0;
      cap_pend_q <= 1'b0;
    end
    else
    begin
      core_q <= core_d;
      first_q <= first_d;
      second_q <= second_d;
      ack_q <= ack_d;
      err_q <= err_d;
      prdata_q <= prdata_d;
      compat_s1_q <= compat_mode_in;
      compat_q <= compat_s1_q;
      low_s1_q <= muxed_low_bus_in;
      low_s2_q <= low_s1_q;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      ext_q <= ext_d;
      cap_pend_q <= cap_pend_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = ack_q;
  assign pslverr_out = ack_q && err_q;
  assign done_out = sq.done;
  assign ext_hit_out = ext_q;
  assign rdata_out = rdata_q;

  // pin muxing
  logic low_drive;
  always_comb
  begin
    low_drive = 1'b0;
    if (!enabled)
    begin
      muxed_low_bus_out = port_low_data_in;
      muxed_low_bus_oe_out = port_low_dir_in;
    end
    else
    begin
      // address during the latch phase, write data after; idle keeps address up
      low_drive = sq.ale || sq.idle || sq.drive_data || !ext_q;
      muxed_low_bus_out = sq.drive_data ? wdata_q : addr_q[LOW_W-1:0];
      muxed_low_bus_oe_out = {LOW_W{low_drive}};
    end
  end

  // keeper: weak hold of the last level seen, only while the port floats the bus
  assign keeper_on_out = enabled && keeper_en && !low_drive;
  assign keeper_level_out = low_s2_q;

  // upper release_cnt pins return to the port
  always_comb
  begin
    for (int i = 0; i < HIGH_W; i++)
    begin
      if (enabled && (i < HIGH_W - int'(release_cnt)))
      begin
        high_address_bus_out[i] = addr_q[LOW_W + i];
        high_address_bus_oe_out[i] = 1'b1;
      end
      else
      begin
        high_address_bus_out[i] = port_high_data_in[i];
        high_address_bus_oe_out[i] = port_high_dir_in[i];
      end
    end
  end

  // control pins: port order is {ale, rd_n, wr_n}
  assign ale_out = enabled ? sq.ale : port_ctrl_data_in[2];
  assign rd_n_out = enabled ? (sq.rd_n || !ext_q) : port_ctrl_data_in[1];
  assign wr_n_out = enabled ? (sq.wr_n || !ext_q) : port_ctrl_data_in[0];
  assign ale_oe_out = enabled || compat_q || port_ctrl_dir_in[2];
  assign rd_n_oe_out = enabled || compat_q || port_ctrl_dir_in[1];
  assign wr_n_oe_out = enabled || compat_q || port_ctrl_dir_in[0];
endmodule

/* File: testbench/ext_mem_port_props.sv */
/*
  Checker for the off-chip memory port pins and APB answer timing.
  Assumes it is bound to ext_mem_port and sees only its ports.
*/
`timescale 1ns/1ps
module ext_mem_port_props (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ext_mem_pkg::APB_AW-1:0] paddr_in,
  input wire logic [ext_mem_pkg::APB_DW-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic pready_out,
  input wire logic [15:0] req_addr_in,
  input wire logic req_next_ram_in,
  input wire logic done_out,
  input wire logic ext_hit_out,
  input wire logic compat_mode_in,
  input wire logic [7:0] port_low_data_in,
  input wire logic [7:0] port_low_dir_in,
  input wire logic [7:0] muxed_low_bus_out,
  input wire logic [7:0] muxed_low_bus_oe_out,
  input wire logic keeper_on_out,
  input wire logic ale_out,
  input wire logic ale_oe_out,
  input wire logic rd_n_out,
  input wire logic rd_n_oe_out,
  input wire logic wr_n_out,
  input wire logic wr_n_oe_out
);
  logic en_q, en_d;
  logic [1:0] rel_q, rel_d;
  logic [2:0] low_q, low_d;
  // enable tracked at the edge that ends the first access cycle, as the port does
  always_comb
  begin
    en_d = en_q;
    if (psel_in && penable_in && !pready_out && pwrite_in && pstrb_in[0] && paddr_in == ext_mem_pkg::OFS_CORE_CTRL)
      en_d = pwdata_in[ext_mem_pkg::CORE_ENABLE_BIT];
    rel_d = (rel_q == 2'h3) ? rel_q : rel_q + 2'h1;
    low_d = (!rd_n_out || !wr_n_out) ? low_q + 3'h1 : 3'h0;
  end
  always_ff @(posedge sys_clk_in)
  begin
    en_q <= reset_in ? 1'b0 : en_d;
    rel_q <= reset_in ? 2'h0 : rel_d;
    low_q <= reset_in ? 3'h0 : low_d;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  apb_answer_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer not in second access cycle");
  ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("pready longer than one cycle");
  strobe_excl_a: assert property (rd_n_out || wr_n_out) else $error("read and write strobes both low");
  ale_transfer_a: assert property (!rd_n_out || !wr_n_out |-> !ale_out)
    else $error("latch high in transfer");
  addr_at_fall_a: assert property ($fell(ale_out) && $past(en_q) && !$past(done_out) |->
    $past(muxed_low_bus_oe_out) == 8'hff && $past(muxed_low_bus_out) == req_addr_in[7:0])
    else $error("no valid address at latch fall");
  done_after_a: assert property (($rose(rd_n_out) || $rose(wr_n_out)) && $past(en_q) |-> done_out)
    else $error("strobe end without done");
  strobe_len_a: assert property (!rd_n_out || !wr_n_out |-> low_q < 3'h4) else $error("strobe too long");
  int_quiet_a: assert property (done_out && !ext_hit_out |-> rd_n_out && wr_n_out)
    else $error("strobe active on internal access");
  ale_next_a: assert property (done_out && ext_hit_out |-> ale_out == req_next_ram_in)
    else $error("final latch pulse wrong");
  ctrl_drive_a: assert property (en_q |-> ale_oe_out && rd_n_oe_out && wr_n_oe_out)
    else $error("control pins not driven while enabled");
  port_revert_a: assert property (!en_q |-> muxed_low_bus_oe_out == port_low_dir_in &&
    muxed_low_bus_out == port_low_data_in) else $error("low bus not on port settings");
  compat_fixed_a: assert property (compat_mode_in && rel_q == 2'h3 |-> rd_n_oe_out && wr_n_oe_out
    && ale_oe_out && !keeper_on_out) else $error("compat pin restrictions broken");
  keeper_float_a: assert property (keeper_on_out |-> muxed_low_bus_oe_out == 8'h00)
    else $error("keeper on while bus driven");
  cover property ($rose(rd_n_out));
  cover property ($rose(wr_n_out));
  cover property (keeper_on_out);
  cover property (low_q == 3'h3);
endmodule
bind ext_mem_port ext_mem_port_props chk (.sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pstrb_in, .pready_out, .req_addr_in, .req_next_ram_in, .done_out, .ext_hit_out, .compat_mode_in,
  .port_low_data_in, .port_low_dir_in, .muxed_low_bus_out, .muxed_low_bus_oe_out, .keeper_on_out, .ale_out,
  .ale_oe_out, .rd_n_out, .rd_n_oe_out, .wr_n_out, .wr_n_oe_out);

/* File: testbench/latch_sram_model.sv */
/*
  Behavioural address latch and byte memory behind the port pins.
  Assumes the port drives the latch gate and strobes; returns the wire level.
*/
`timescale 1ns/1ps
module latch_sram_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] bus_out_in,
  input wire logic [7:0] bus_oe_in,
  input wire logic [7:0] high_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  output logic [7:0] bus_level_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] low_lat;
  logic [7:0] last_q;
  logic rd_q;
  always_latch
  begin
    if (ale_in)
      low_lat <= bus_level_out;
  end
  // data held one cycle past the strobe; released lines show the inverse of the last level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      bus_level_out[i] = bus_oe_in[i] ? bus_out_in[i] : (!rd_n_in || rd_q) ? mem[{high_in, low_lat}][i] : !last_q[i];
  end
  always_ff @(posedge sys_clk_in)
  begin
    rd_q <= !rd_n_in;
    last_q <= bus_level_out;
    // write while the strobe is low: a final latch pulse may already carry write data
    if (!wr_n_in)
      mem[{high_in, low_lat}] <= bus_level_out;
  end
endmodule

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the off-chip memory port: APB and core access tasks.
  Assumes the checker binds itself and the memory model sits on the pins.
*/
`timescale 1ns/1ps
module testbench;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd_v;
  logic [3:0] pstrb_in = 4'hf;
  logic req_in = 1'b0, req_write_in = 1'b0, req_next_ram_in = 1'b0, compat_mode_in = 1'b0;
  logic [15:0] req_addr_in = 16'h0;
  logic [7:0] req_wdata_in = 8'h0, port_low_data_in = 8'h5a, port_low_dir_in = 8'hc3;
  logic [7:0] port_high_data_in = 8'h00, port_high_dir_in = 8'h1e;
  logic [2:0] port_ctrl_data_in = 3'h3, port_ctrl_dir_in = 3'h0;
  logic pready_out, pslverr_out, done_out, ext_hit_out, keeper_on_out, err_v, x_v;
  logic ale_out, ale_oe_out, rd_n_out, rd_n_oe_out, wr_n_out, wr_n_oe_out;
  logic [7:0] rdata_out, muxed_low_bus_in, muxed_low_bus_out, muxed_low_bus_oe_out, keeper_level_out, data_v;
  logic [7:0] high_address_bus_out, high_address_bus_oe_out;
  int fail_count = 0, checks = 0, cyc = 0, n;
  ext_mem_port uut (.sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
    .prdata_out, .pready_out, .pslverr_out, .req_in, .req_write_in, .req_addr_in, .req_wdata_in, .req_next_ram_in,
    .done_out, .ext_hit_out, .rdata_out, .compat_mode_in, .port_low_data_in, .port_low_dir_in, .port_high_data_in,
    .port_high_dir_in, .port_ctrl_data_in, .port_ctrl_dir_in, .muxed_low_bus_in, .muxed_low_bus_out,
    .muxed_low_bus_oe_out, .keeper_on_out, .keeper_level_out, .high_address_bus_out, .high_address_bus_oe_out,
    .ale_out, .ale_oe_out, .rd_n_out, .rd_n_oe_out, .wr_n_out, .wr_n_oe_out);
  latch_sram_model mem_model (.sys_clk_in, .bus_out_in(muxed_low_bus_out), .bus_oe_in(muxed_low_bus_oe_out),
    .high_in(high_address_bus_out), .ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .bus_level_out(muxed_low_bus_in));
  initial
  begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd_v = prdata_out;
    err_v = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // n counts edges from the request to the edge that sees done
  task automatic run(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic nr, input int en,
    input logic ex);
    req_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_next_ram_in <= nr;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (done_out !== 1'b1 && n < 20);
    x_v = ext_hit_out;
    req_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    data_v = rdata_out;
    chk(n, en);
    chk(x_v, ex);
  endtask
  initial
  begin
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd_v, 32'h0);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
    apb(1'b1, ext_mem_pkg::OFS_STATUS, 32'h7);
    chk(err_v, 1'b1);
    $display("test registers done");
    run(1'b1, 16'h2000, 8'h11, 1'b0, 2, 1'b0);
    run(1'b0, 16'h2000, 8'h00, 1'b0, 2, 1'b0);
    chk(data_v, 8'h00);
    chk({ale_oe_out, rd_n_oe_out, wr_n_oe_out}, 3'h0);
    $display("test disabled done");
    for (int w = 0; w < 4; w++)
    begin
      apb(1'b1, ext_mem_pkg::OFS_CORE_CTRL, 32'h80 | (w & 1) << 6);
      apb(1'b1, ext_mem_pkg::OFS_CTRL_FIRST, (w >> 1) << 1);
      run(1'b1, 16'(16'h2000 + w), 8'(8'ha0 + w), w[0], 4 + w, 1'b1);
      run(1'b0, 16'(16'h2000 + w), 8'h00, 1'b1, 4 + w, 1'b1);
      chk(data_v, 8'ha0 + w);
    end
    apb(1'b0, ext_mem_pkg::OFS_STATUS, 32'h0);
    chk(rd_v, 32'h4);
    run(1'b0, 16'h10ff, 8'h00, 1'b0, 2, 1'b0);
    run(1'b1, 16'h1100, 8'h3c, 1'b0, 7, 1'b1);
    $display("test wait states done");
    apb(1'b1, ext_mem_pkg::OFS_CORE_CTRL, 32'h80);
    apb(1'b1, ext_mem_pkg::OFS_CTRL_FIRST, 32'h2c);
    run(1'b1, 16'h3000, 8'h77, 1'b0, 7, 1'b1);
    run(1'b0, 16'h3000, 8'h00, 1'b0, 7, 1'b1);
    chk(data_v, 8'h77);
    run(1'b1, 16'h4000, 8'h99, 1'b0, 4, 1'b1);
    $display("test sectors done");
    apb(1'b1, ext_mem_pkg::OFS_CTRL_SECOND, 32'h83);
    apb(1'b0, ext_mem_pkg::OFS_CTRL_SECOND, 32'h0);
    chk(rd_v, 32'h83);
    run(1'b1, 16'h4055, 8'h66, 1'b0, 4, 1'b1);
    run(1'b0, 16'h4055, 8'h00, 1'b0, 4, 1'b1);
    chk(data_v, 8'h66);
    chk(keeper_level_out, 8'h55);
    chk(high_address_bus_oe_out, {port_high_dir_in[7:5], 5'h1f});
    $display("test release and keeper done");
    compat_mode_in <= 1'b1;
    do_reset();
    chk({ale_oe_out, rd_n_oe_out, wr_n_oe_out}, 3'h7);
    apb(1'b1, ext_mem_pkg::OFS_CTRL_FIRST, 32'h02);
    chk(err_v, 1'b1);
    apb(1'b0, ext_mem_pkg::OFS_CTRL_FIRST, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b1, ext_mem_pkg::OFS_CTRL_SECOND, 32'h83);
    chk(err_v, 1'b1);
    apb(1'b1, ext_mem_pkg::OFS_CORE_CTRL, 32'hc0);
    apb(1'b0, ext_mem_pkg::OFS_STATUS, 32'h0);
    chk(rd_v, 32'h6);
    run(1'b1, 16'h1000, 8'h5e, 1'b0, 5, 1'b1);
    run(1'b0, 16'h0fff, 8'h00, 1'b0, 2, 1'b0);
    $display("test compatibility done");
    close_out();
  end
endmodule
